//--- verilog/serial_audio_mux_defines.svh
// constants for the serial audio pin mux: pin slots, mode codes, limits
// assumes inclusion by bare name from the mux files and the far side model
// Operation
// - default mode: peripheral port plus codec link
// - i2s on peripheral pins, no master clock
// - i2s on codec pins, reset pin carries mclk
// - i2s never on both pin groups
// - routed group belongs wholly to i2s
// - peripheral port master or slave, three formats
// - i2s stereo samples up to 24 bits
// - codec link: many outputs, one stereo input
`ifndef SERIAL_AUDIO_MUX_DEFINES_SVH
`define SERIAL_AUDIO_MUX_DEFINES_SVH

// pin slots in the internal pin vectors
`define PIN_COUNT          9
`define PIN_PERIPH_CLK     0
`define PIN_PERIPH_FRM     1
`define PIN_PERIPH_IN      2
`define PIN_PERIPH_OUT     3
`define PIN_LINK_RST       4
`define PIN_LINK_BCLK      5
`define PIN_LINK_SYNC      6
`define PIN_LINK_IN        7
`define PIN_LINK_OUT       8

// mode select codes
`define MODE_NORMAL        2'h0
`define MODE_I2S_ON_PERIPH 2'h1
`define MODE_I2S_ON_LINK   2'h2

// format codes of the peripheral port
`define FMT_SPI            2'h0
`define FMT_TI             2'h1
`define FMT_MICROWIRE      2'h2

// limits
`define I2S_MAX_BITS       5'h18
`define SYNC_STAGES        2

`endif

//--- verilog/serial_audio_mux_pkg.sv
// types for the serial audio pin mux
// assumes the defines header sits beside it
`include "serial_audio_mux_defines.svh"

package serial_audio_mux_pkg;

  typedef enum logic [1:0] {
    ROUTE_NORMAL        = 2'b00,
    ROUTE_I2S_ON_PERIPH = 2'b01,
    ROUTE_I2S_ON_LINK   = 2'b10
  } route_mode_t;

  typedef enum logic [1:0] {
    FORMAT_SPI       = 2'b00,
    FORMAT_TI        = 2'b01,
    FORMAT_MICROWIRE = 2'b10
  } frame_format_t;

endpackage

//--- verilog/pin_input_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
// assumes every bit is independent and comes from outside core_clk
`timescale 1ns/1ns
`include "serial_audio_mux_defines.svh"

module pin_input_sync #(
  parameter int WIDTH = `PIN_COUNT
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = raw_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

//--- verilog/serial_audio_port_mux.sv
// pin mux placing the i2s port on the peripheral pins or the codec link pins
// assumes the serial engines run on core_clk; link clocks are sampled pins
`timescale 1ns/1ns
`include "serial_audio_mux_defines.svh"

module serial_audio_port_mux
  import serial_audio_mux_pkg::*;
#(
  parameter int AC_CODECS = 4
) (
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  // mode setting from software
  input  wire logic [1:0]           route_mode,
  // sync_serial_port engine side
  input  wire logic                 ssp_master,
  input  wire logic [1:0]           ssp_format,
  input  wire logic                 ssp_clk_out,
  input  wire logic                 ssp_frm_out,
  input  wire logic                 ssp_tx,
  output logic                      ssp_clk_in,
  output logic                      ssp_frm_in,
  output logic                      ssp_rx,
  output logic                      ssp_frame_active,
  output logic [1:0]                ssp_format_used,
  // i2s engine side
  input  wire logic                 i2s_master,
  input  wire logic                 i2s_mclk,
  input  wire logic                 i2s_sclk_out,
  input  wire logic                 i2s_lrclk_out,
  input  wire logic                 i2s_sdo,
  input  wire logic [4:0]           i2s_word_bits,
  output logic                      i2s_sclk_in,
  output logic                      i2s_lrclk_in,
  output logic                      i2s_sdi,
  output logic [4:0]                i2s_sample_bits,
  // codec link engine side
  input  wire logic                 ac_reset_n,
  input  wire logic                 ac_sync,
  input  wire logic                 ac_sdo,
  input  wire logic [AC_CODECS-1:0] ac_out_codecs,
  output logic                      ac_bclk_in,
  output logic                      ac_sdi,
  output logic [AC_CODECS-1:0]      ac_in_codec,
  // status
  output logic                      ssp_active,
  output logic                      ac_active,
  output logic                      i2s_on_periph,
  output logic                      i2s_on_link,
  // peripheral pin group
  input  wire logic                 periph_bit_clock_pin_in,
  output logic                      periph_bit_clock_pin_out,
  output logic                      periph_bit_clock_pin_oe,
  input  wire logic                 periph_frame_pin_in,
  output logic                      periph_frame_pin_out,
  output logic                      periph_frame_pin_oe,
  input  wire logic                 periph_serial_in_pin_in,
  output logic                      periph_serial_in_pin_out,
  output logic                      periph_serial_in_pin_oe,
  input  wire logic                 periph_serial_out_pin_in,
  output logic                      periph_serial_out_pin_out,
  output logic                      periph_serial_out_pin_oe,
  // codec link pin group
  input  wire logic                 codec_link_reset_pin_in,
  output logic                      codec_link_reset_pin_out,
  output logic                      codec_link_reset_pin_oe,
  input  wire logic                 codec_link_bit_clock_pin_in,
  output logic                      codec_link_bit_clock_pin_out,
  output logic                      codec_link_bit_clock_pin_oe,
  input  wire logic                 codec_link_sync_pin_in,
  output logic                      codec_link_sync_pin_out,
  output logic                      codec_link_sync_pin_oe,
  input  wire logic                 codec_link_serial_in_pin_in,
  output logic                      codec_link_serial_in_pin_out,
  output logic                      codec_link_serial_in_pin_oe,
  input  wire logic                 codec_link_serial_out_pin_in,
  output logic                      codec_link_serial_out_pin_out,
  output logic                      codec_link_serial_out_pin_oe
);

  // frame level that marks an active word for a given format
  function automatic logic frame_is_active(input logic [1:0] fmt, input logic frm);
    frame_is_active = (fmt == `FMT_TI) ? frm : ~frm;
  endfunction

  // lowest set codec: the single input stream source
  function automatic logic [AC_CODECS-1:0] lowest_codec(input logic [AC_CODECS-1:0] m);
    lowest_codec = m & (~m + {{(AC_CODECS-1){1'b0}}, 1'b1});
  endfunction

  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_sync;

  assign pin_raw = {codec_link_serial_out_pin_in, codec_link_serial_in_pin_in,
                    codec_link_sync_pin_in, codec_link_bit_clock_pin_in,
                    codec_link_reset_pin_in, periph_serial_out_pin_in,
                    periph_serial_in_pin_in, periph_frame_pin_in,
                    periph_bit_clock_pin_in};

  pin_input_sync #(
    .WIDTH    (`PIN_COUNT)
  ) u_pin_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .raw_in   (pin_raw),
    .sync_out (pin_sync)
  );

  // mode state
  route_mode_t mode;
  route_mode_t next_mode;

  always_comb begin
    unique case (route_mode)
      `MODE_I2S_ON_PERIPH: next_mode = ROUTE_I2S_ON_PERIPH;
      `MODE_I2S_ON_LINK:   next_mode = ROUTE_I2S_ON_LINK;
      default:             next_mode = ROUTE_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode <= ROUTE_NORMAL;
    end else if (ce) begin
      mode <= next_mode;
    end
  end

  // pin drive and engine-side returns
  logic [`PIN_COUNT-1:0] pin_out;
  logic [`PIN_COUNT-1:0] pin_oe;
  logic [`PIN_COUNT-1:0] next_pin_out;
  logic [`PIN_COUNT-1:0] next_pin_oe;
  logic                  next_ssp_clk_in;
  logic                  next_ssp_frm_in;
  logic                  next_ssp_rx;
  logic                  next_ssp_frame_active;
  logic                  next_i2s_sclk_in;
  logic                  next_i2s_lrclk_in;
  logic                  next_i2s_sdi;
  logic                  next_ac_bclk_in;
  logic                  next_ac_sdi;
  logic                  periph_frm_level;

  always_comb begin
    next_pin_out          = '0;
    next_pin_oe           = '0;
    next_ssp_clk_in       = 1'b0;
    next_ssp_frm_in       = ~frame_is_active(ssp_format, 1'b1);
    next_ssp_rx           = 1'b0;
    next_ssp_frame_active = 1'b0;
    next_i2s_sclk_in      = 1'b0;
    next_i2s_lrclk_in     = 1'b0;
    next_i2s_sdi          = 1'b0;
    next_ac_bclk_in       = 1'b0;
    next_ac_sdi           = 1'b0;
    periph_frm_level      = ssp_master ? ssp_frm_out : pin_sync[`PIN_PERIPH_FRM];
    // peripheral pin group
    if (mode == ROUTE_I2S_ON_PERIPH) begin
      next_pin_out[`PIN_PERIPH_CLK] = i2s_sclk_out;
      next_pin_oe[`PIN_PERIPH_CLK]  = i2s_master;
      next_pin_out[`PIN_PERIPH_FRM] = i2s_lrclk_out;
      next_pin_oe[`PIN_PERIPH_FRM]  = i2s_master;
      next_pin_out[`PIN_PERIPH_OUT] = i2s_sdo;
      next_pin_oe[`PIN_PERIPH_OUT]  = 1'b1;
      next_i2s_sclk_in              = pin_sync[`PIN_PERIPH_CLK];
      next_i2s_lrclk_in             = pin_sync[`PIN_PERIPH_FRM];
      next_i2s_sdi                  = pin_sync[`PIN_PERIPH_IN];
    end else begin
      next_pin_out[`PIN_PERIPH_CLK] = ssp_clk_out;
      next_pin_oe[`PIN_PERIPH_CLK]  = ssp_master;
      next_pin_out[`PIN_PERIPH_FRM] = ssp_frm_out;
      next_pin_oe[`PIN_PERIPH_FRM]  = ssp_master;
      next_ssp_frame_active         = frame_is_active(ssp_format, periph_frm_level);
      next_pin_out[`PIN_PERIPH_OUT] = ssp_tx;
      next_pin_oe[`PIN_PERIPH_OUT]  = ssp_master | next_ssp_frame_active;
      next_ssp_clk_in               = pin_sync[`PIN_PERIPH_CLK];
      next_ssp_frm_in               = pin_sync[`PIN_PERIPH_FRM];
      next_ssp_rx                   = pin_sync[`PIN_PERIPH_IN];
    end
    // codec link pin group
    if (mode == ROUTE_I2S_ON_LINK) begin
      next_pin_out[`PIN_LINK_RST]  = i2s_mclk;
      next_pin_oe[`PIN_LINK_RST]   = 1'b1;
      next_pin_out[`PIN_LINK_BCLK] = i2s_sclk_out;
      next_pin_oe[`PIN_LINK_BCLK]  = i2s_master;
      next_pin_out[`PIN_LINK_SYNC] = i2s_lrclk_out;
      next_pin_oe[`PIN_LINK_SYNC]  = i2s_master;
      next_pin_out[`PIN_LINK_OUT]  = i2s_sdo;
      next_pin_oe[`PIN_LINK_OUT]   = 1'b1;
      next_i2s_sclk_in             = pin_sync[`PIN_LINK_BCLK];
      next_i2s_lrclk_in            = pin_sync[`PIN_LINK_SYNC];
      next_i2s_sdi                 = pin_sync[`PIN_LINK_IN];
    end else begin
      next_pin_out[`PIN_LINK_RST]  = ac_reset_n;
      next_pin_oe[`PIN_LINK_RST]   = 1'b1;
      next_pin_out[`PIN_LINK_SYNC] = ac_sync;
      next_pin_oe[`PIN_LINK_SYNC]  = 1'b1;
      next_pin_out[`PIN_LINK_OUT]  = ac_sdo;
      next_pin_oe[`PIN_LINK_OUT]   = 1'b1;
      next_ac_bclk_in              = pin_sync[`PIN_LINK_BCLK];
      next_ac_sdi                  = pin_sync[`PIN_LINK_IN];
    end
  end

  // sample width clamp and codec input choice
  logic [4:0]           next_i2s_sample_bits;
  logic [AC_CODECS-1:0] next_ac_in_codec;
  logic [1:0]           next_ssp_format_used;

  always_comb begin
    next_i2s_sample_bits = (i2s_word_bits > `I2S_MAX_BITS) ? `I2S_MAX_BITS
                                                           : i2s_word_bits;
    next_ac_in_codec     = lowest_codec(ac_out_codecs);
    next_ssp_format_used = (ssp_format == `FMT_TI || ssp_format == `FMT_MICROWIRE)
                           ? ssp_format : `FMT_SPI;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_out          <= '0;
      pin_oe           <= '0;
      ssp_clk_in       <= 1'b0;
      ssp_frm_in       <= 1'b1;
      ssp_rx           <= 1'b0;
      ssp_frame_active <= 1'b0;
      i2s_sclk_in      <= 1'b0;
      i2s_lrclk_in     <= 1'b0;
      i2s_sdi          <= 1'b0;
      ac_bclk_in       <= 1'b0;
      ac_sdi           <= 1'b0;
      i2s_sample_bits  <= `I2S_MAX_BITS;
      ac_in_codec      <= '0;
      ssp_format_used  <= `FMT_SPI;
    end else if (ce) begin
      pin_out          <= next_pin_out;
      pin_oe           <= next_pin_oe;
      ssp_clk_in       <= next_ssp_clk_in;
      ssp_frm_in       <= next_ssp_frm_in;
      ssp_rx           <= next_ssp_rx;
      ssp_frame_active <= next_ssp_frame_active;
      i2s_sclk_in      <= next_i2s_sclk_in;
      i2s_lrclk_in     <= next_i2s_lrclk_in;
      i2s_sdi          <= next_i2s_sdi;
      ac_bclk_in       <= next_ac_bclk_in;
      ac_sdi           <= next_ac_sdi;
      i2s_sample_bits  <= next_i2s_sample_bits;
      ac_in_codec      <= next_ac_in_codec;
      ssp_format_used  <= next_ssp_format_used;
    end
  end

  // status from the mode register; only one i2s group can be set
  assign ssp_active    = (mode != ROUTE_I2S_ON_PERIPH);
  assign ac_active     = (mode != ROUTE_I2S_ON_LINK);
  assign i2s_on_periph = (mode == ROUTE_I2S_ON_PERIPH);
  assign i2s_on_link   = (mode == ROUTE_I2S_ON_LINK);

  // pin ports from the pin registers
  assign periph_bit_clock_pin_out      = pin_out[`PIN_PERIPH_CLK];
  assign periph_bit_clock_pin_oe       = pin_oe[`PIN_PERIPH_CLK];
  assign periph_frame_pin_out          = pin_out[`PIN_PERIPH_FRM];
  assign periph_frame_pin_oe           = pin_oe[`PIN_PERIPH_FRM];
  assign periph_serial_in_pin_out      = pin_out[`PIN_PERIPH_IN];
  assign periph_serial_in_pin_oe       = pin_oe[`PIN_PERIPH_IN];
  assign periph_serial_out_pin_out     = pin_out[`PIN_PERIPH_OUT];
  assign periph_serial_out_pin_oe      = pin_oe[`PIN_PERIPH_OUT];
  assign codec_link_reset_pin_out      = pin_out[`PIN_LINK_RST];
  assign codec_link_reset_pin_oe       = pin_oe[`PIN_LINK_RST];
  assign codec_link_bit_clock_pin_out  = pin_out[`PIN_LINK_BCLK];
  assign codec_link_bit_clock_pin_oe   = pin_oe[`PIN_LINK_BCLK];
  assign codec_link_sync_pin_out       = pin_out[`PIN_LINK_SYNC];
  assign codec_link_sync_pin_oe        = pin_oe[`PIN_LINK_SYNC];
  assign codec_link_serial_in_pin_out  = pin_out[`PIN_LINK_IN];
  assign codec_link_serial_in_pin_oe   = pin_oe[`PIN_LINK_IN];
  assign codec_link_serial_out_pin_out = pin_out[`PIN_LINK_OUT];
  assign codec_link_serial_out_pin_oe  = pin_oe[`PIN_LINK_OUT];

endmodule

//--- dv/serial_audio_mux_props.sv
// assertions on the serial audio pin mux top ports
// assumes binding onto serial_audio_port_mux, checks gated by nrst and ce
`timescale 1ns/1ns
module serial_audio_mux_props
  import serial_audio_mux_pkg::*;
#(
  parameter int AC_CODECS = 4
) (
  // clock, reset, enable
  input wire logic                 core_clk, nrst, ce,
  // engine side
  input wire logic [1:0]           route_mode, ssp_format, ssp_format_used,
  input wire logic                 ssp_master, ssp_tx, i2s_master, i2s_mclk, i2s_sdo, ac_sdo,
  input wire logic [4:0]           i2s_word_bits, i2s_sample_bits,
  input wire logic [AC_CODECS-1:0] ac_out_codecs, ac_in_codec,
  // status
  input wire logic                 ssp_active, ac_active, i2s_on_periph, i2s_on_link,
  // pins
  input wire logic                 periph_bit_clock_pin_oe, periph_serial_in_pin_oe,
  input wire logic                 periph_serial_out_pin_out, periph_serial_out_pin_oe,
  input wire logic                 codec_link_reset_pin_out, codec_link_reset_pin_oe,
  input wire logic                 codec_link_serial_out_pin_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || !ce);

  no_i2s_both_a: assert property (!(i2s_on_periph && i2s_on_link))
    else $error("i2s on both pin groups");
  group_owner_a: assert property (ssp_active != i2s_on_periph && ac_active != i2s_on_link)
    else $error("pin group shared");
  mode_take_a: assert property (nrst && ce && route_mode == 2'h1 |=> i2s_on_periph)
    else $error("mode not taken");
  normal_pins_a: assert property (nrst && ce && ssp_active && ac_active |=>
    periph_serial_out_pin_out == $past(ssp_tx) && periph_bit_clock_pin_oe == $past(ssp_master)
    && codec_link_serial_out_pin_out == $past(ac_sdo) && codec_link_reset_pin_oe)
    else $error("normal routing wrong");
  periph_pins_a: assert property (nrst && ce && i2s_on_periph |=>
    periph_serial_out_pin_out == $past(i2s_sdo) && periph_serial_out_pin_oe
    && !periph_serial_in_pin_oe && periph_bit_clock_pin_oe == $past(i2s_master))
    else $error("i2s on peripheral pins wrong");
  link_mclk_a: assert property (nrst && ce && i2s_on_link |=>
    codec_link_reset_pin_out == $past(i2s_mclk) && codec_link_reset_pin_oe
    && codec_link_serial_out_pin_out == $past(i2s_sdo))
    else $error("i2s on codec pins wrong");
  width_clamp_a: assert property (nrst && ce |=>
    i2s_sample_bits == ($past(i2s_word_bits) > 5'h18 ? 5'h18 : $past(i2s_word_bits)))
    else $error("sample width wrong");
  one_input_a: assert property (nrst && ce |=>
    ac_in_codec == ($past(ac_out_codecs) & (~$past(ac_out_codecs) + 1'b1)))
    else $error("input codec wrong");
  format_map_a: assert property (nrst && ce |=>
    ssp_format_used == ($past(ssp_format) == 2'h3 ? 2'h0 : $past(ssp_format)))
    else $error("frame format wrong");

  periph_cov: cover property (i2s_on_periph ##1 i2s_on_periph);
  link_cov: cover property (i2s_on_link ##1 i2s_on_link);
  clamp_cov: cover property (i2s_word_bits > 5'h18);
endmodule

bind serial_audio_port_mux serial_audio_mux_props #(.AC_CODECS(AC_CODECS)) props (.*);

//--- dv/pin_far_side.sv
// far side model: codecs and serial peripherals on the nine pins
// assumes pin vectors in the mux pin-slot order
`timescale 1ns/1ns
`include "serial_audio_mux_defines.svh"
module pin_far_side #(
  parameter logic [8:0] DRIVEN = 9'h0a6
) (
  // clock for the released-line pattern
  input  wire logic       core_clk,
  // link clock runs only while high
  input  wire logic       frame_run,
  // device side of the pins
  input  wire logic [8:0] pin_out,
  input  wire logic [8:0] pin_oe,
  // far side levels
  input  wire logic [8:0] ext_val,
  output logic      [8:0] pin_in
);
  logic link_clk = 1'b0;
  logic idle = 1'b0;

  // link clock stands still between frames
  initial #3 forever #40 link_clk = frame_run ? ~link_clk : link_clk;
  // released lines that the far side does not drive change every cycle
  always @(posedge core_clk) idle <= ~idle;
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : !DRIVEN[i] ? idle : ext_val[i];
    end
    if (!pin_oe[`PIN_LINK_BCLK]) pin_in[`PIN_LINK_BCLK] = link_clk;
  end
endmodule

//--- dv/testbench.sv
// self-checking bench of the serial audio pin mux
// assumes the far side model and the bound checker
`timescale 1ns/1ns
module testbench;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        frame_run = 1'b0;
  logic [1:0]  route_mode = 2'h0;
  logic [1:0]  ssp_format = 2'h0;
  logic [11:0] eng = 12'h000;
  logic [4:0]  i2s_word_bits = 5'h00;
  logic [3:0]  ac_out_codecs = 4'h0;
  wire  [8:0]  po, oe, pin_in;
  wire  [4:0]  i2s_sample_bits;
  wire  [3:0]  ac_in_codec;
  wire  [1:0]  ssp_format_used;
  wire         ssp_clk_in, ssp_frm_in, ssp_rx, ssp_frame_active, i2s_sclk_in, i2s_lrclk_in;
  wire         i2s_sdi, ac_bclk_in, ac_sdi, ssp_active, ac_active, i2s_on_periph, i2s_on_link;
  integer      failures = 0;
  integer      checks_done = 0;

  always #4 core_clk = ~core_clk;

  serial_audio_port_mux #(.AC_CODECS(4)) DUT (
    .core_clk, .nrst, .ce, .route_mode, .ssp_format, .i2s_word_bits, .ac_out_codecs,
    .ssp_master(eng[0]), .ssp_clk_out(eng[1]), .ssp_frm_out(eng[2]), .ssp_tx(eng[3]),
    .i2s_master(eng[4]), .i2s_mclk(eng[5]), .i2s_sclk_out(eng[6]), .i2s_lrclk_out(eng[7]),
    .i2s_sdo(eng[8]), .ac_reset_n(eng[9]), .ac_sync(eng[10]), .ac_sdo(eng[11]),
    .ssp_clk_in, .ssp_frm_in, .ssp_rx, .ssp_frame_active, .ssp_format_used, .i2s_sclk_in,
    .i2s_lrclk_in, .i2s_sdi, .i2s_sample_bits, .ac_bclk_in, .ac_sdi, .ac_in_codec,
    .ssp_active, .ac_active, .i2s_on_periph, .i2s_on_link,
    .periph_bit_clock_pin_in(pin_in[0]), .periph_bit_clock_pin_out(po[0]),
    .periph_bit_clock_pin_oe(oe[0]), .periph_frame_pin_in(pin_in[1]),
    .periph_frame_pin_out(po[1]), .periph_frame_pin_oe(oe[1]),
    .periph_serial_in_pin_in(pin_in[2]), .periph_serial_in_pin_out(po[2]),
    .periph_serial_in_pin_oe(oe[2]), .periph_serial_out_pin_in(pin_in[3]),
    .periph_serial_out_pin_out(po[3]), .periph_serial_out_pin_oe(oe[3]),
    .codec_link_reset_pin_in(pin_in[4]), .codec_link_reset_pin_out(po[4]),
    .codec_link_reset_pin_oe(oe[4]), .codec_link_bit_clock_pin_in(pin_in[5]),
    .codec_link_bit_clock_pin_out(po[5]), .codec_link_bit_clock_pin_oe(oe[5]),
    .codec_link_sync_pin_in(pin_in[6]), .codec_link_sync_pin_out(po[6]),
    .codec_link_sync_pin_oe(oe[6]), .codec_link_serial_in_pin_in(pin_in[7]),
    .codec_link_serial_in_pin_out(po[7]), .codec_link_serial_in_pin_oe(oe[7]),
    .codec_link_serial_out_pin_in(pin_in[8]), .codec_link_serial_out_pin_out(po[8]),
    .codec_link_serial_out_pin_oe(oe[8])
  );

  pin_far_side far (.core_clk, .frame_run, .pin_out(po), .pin_oe(oe), .ext_val(9'h084),
    .pin_in);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic t_normal;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      route_mode <= (i < 2) ? 2'h0 : 2'h3;
      eng <= 12'he0a | 12'(i % 2);
      wait_n(6);
      check(oe, 9'h158 | 9'(i % 2) * 9'h003, "normal enables");
      check(po & oe, 9'h158 | 9'(i % 2), "normal pin levels");
      check({ssp_active, ac_active, i2s_on_periph, i2s_on_link}, 4'hc, "normal status");
      check({ssp_rx, ac_sdi, i2s_sdi}, 3'h6, "normal inputs");
    end
    for (int f = 0; f < 4; f++) begin
      @(posedge core_clk);
      ssp_format <= 2'(f);
      wait_n(6);
      check(ssp_format_used, (f == 3) ? 9'h0 : 9'(f), "format code");
      check(ssp_frame_active, (f == 1) ? 9'h0 : 9'h1, "frame polarity");
    end
  endtask

  task automatic t_periph;
    @(posedge core_clk);
    route_mode <= 2'h1;
    eng <= 12'hfb1;
    wait_n(6);
    check(oe, 9'h15b, "periph mode enables");
    check(po & oe, 9'h15a, "periph mode levels");
    check({ssp_active, ac_active, i2s_on_periph, i2s_on_link}, 4'h6, "periph status");
    check({ssp_rx, ac_sdi, i2s_sdi}, 3'h3, "periph mode inputs");
    check({ssp_clk_in, ssp_frm_in, i2s_sclk_in, i2s_lrclk_in}, 4'h5, "periph mode clocks");
  endtask

  task automatic t_link;
    logic hi;
    logic lo;
    @(posedge core_clk);
    route_mode <= 2'h2;
    eng <= 12'h8bb;
    wait_n(6);
    check(oe, 9'h17b, "link mode enables");
    check(po & oe, 9'h059, "link mode levels");
    check({ssp_active, ac_active, i2s_on_periph, i2s_on_link}, 4'h9, "link status");
    check({ssp_rx, ac_sdi, i2s_sdi}, 3'h5, "link mode inputs");
    check({ssp_clk_in, ssp_frm_in, i2s_sclk_in, i2s_lrclk_in}, 4'h9, "link mode clocks");
    @(posedge core_clk);
    eng <= 12'h8ab;
    frame_run <= 1'b1;
    hi = 1'b0;
    lo = 1'b0;
    repeat (40) begin
      wait_n(1);
      hi = hi | i2s_sclk_in;
      lo = lo | !i2s_sclk_in;
    end
    check({hi, lo, oe[5], ac_bclk_in}, 4'hc, "slave serial clock");
    @(posedge core_clk);
    frame_run <= 1'b0;
  endtask

  task automatic t_midreset;
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    check({oe, i2s_on_link}, 10'h0, "reset in mid-run");
    wait_n(4);
    check(i2s_on_link, 9'h1, "mode after reset");
  endtask

  task automatic t_width;
    for (int w = 23; w < 32; w++) begin
      @(posedge core_clk);
      i2s_word_bits <= 5'(w);
      wait_n(2);
      check(i2s_sample_bits, (w > 24) ? 9'h18 : 9'(w), "sample width");
    end
  endtask

  task automatic t_codecs;
    for (int c = 0; c < 16; c++) begin
      @(posedge core_clk);
      ac_out_codecs <= 4'(c);
      wait_n(2);
      check(ac_in_codec, 9'(c & -c), "input codec");
    end
  endtask

  task automatic t_freeze;
    @(posedge core_clk);
    ce <= 1'b0;
    route_mode <= 2'h0;
    ac_out_codecs <= 4'h8;
    wait_n(4);
    check({ssp_active, ac_active, i2s_on_periph, i2s_on_link}, 4'h9, "mode frozen");
    check(ac_in_codec, 9'h1, "codec choice frozen");
    @(posedge core_clk);
    ce <= 1'b1;
    wait_n(4);
    check({ssp_active, ac_active, i2s_on_periph, i2s_on_link}, 4'hc, "mode after freeze");
    check(ac_in_codec, 9'h8, "codec choice after freeze");
  endtask

  initial begin
    wait_n(3);
    check(oe | po, 9'h0, "pins in reset");
    check({i2s_sample_bits, ssp_frm_in}, 9'h031, "outputs in reset");
    @(posedge core_clk);
    nrst <= 1'b1;
    t_normal;
    t_periph;
    t_link;
    t_midreset;
    t_width;
    t_codecs;
    t_freeze;
    results;
  end

  initial begin
    #20000;
    failures++;
    results;
  end
endmodule
